// ### design/usbu_regs.svh
/*
  Register offsets, field positions, reset values and counts of the USB bridge UART core.
  Assumes word indices on the plain register port and a 25 MHz core clock.
*/
`ifndef USBU_REGS_SVH
`define USBU_REGS_SVH
`define USBU_CTRL_ADDR  4'h0
`define USBU_BAUD_ADDR  4'h1
`define USBU_STAT_ADDR  4'h2
`define USBU_DATA_ADDR  4'h3
`define USBU_DIR_ADDR   4'h4
`define USBU_CTRL_RST   10'h001
`define USBU_BAUD_RST   17'h10138
`define USBU_DIR_RST    4'h0
`define USBU_BAUD_N     0
`define USBU_BAUD_FRAC  14
`define USBU_ST_FERR    0
`define USBU_ST_BRK     1
`define USBU_ST_OVR     2
`define USBU_ST_PERR    3
`define USBU_ST_DROP    7
`define USBU_CLK_MHZ    25
`define USBU_REF_MHZ    48
`define USBU_FIFO_DEPTH 512
`define USBU_FIFO_AW    9
`define USBU_RTS_LIMIT  10'h1E0
`define USBU_XON        8'h11
`define USBU_XOFF       8'h13
`endif

// ### design/usbu_pkg.sv
/*
  Types of the USB bridge UART core.
  Assumes usbu_regs.svh for all numeric constants.
*/
package usbu_pkg;
  typedef enum logic [1:0] {
    USBU_MODE_UART = 2'h0,
    USBU_MODE_ABB  = 2'h1,
    USBU_MODE_SBB  = 2'h2
  } usbu_mode_type;
  typedef enum logic [2:0] {
    USBU_PAR_NONE  = 3'h0,
    USBU_PAR_ODD   = 3'h1,
    USBU_PAR_EVEN  = 3'h2,
    USBU_PAR_MARK  = 3'h3,
    USBU_PAR_SPACE = 3'h4
  } usbu_parity_type;
  typedef enum logic [4:0] {
    SER_IDLE  = 5'h01,
    SER_START = 5'h02,
    SER_DATA  = 5'h04,
    SER_PAR   = 5'h08,
    SER_STOP  = 5'h10
  } usbu_ser_state_type;
  typedef enum logic [3:0] {
    CFG_DRV0  = 4'h0,
    CFG_DRV1  = 4'h1,
    CFG_RS485 = 4'h2,
    CFG_WRSTB = 4'h3,
    CFG_RDSTB = 4'h4,
    CFG_CLK   = 4'h5
  } usbu_cfg_func_type;
  typedef struct packed {
    usbu_mode_type   mode;
    logic            brk;
    logic            xon;
    logic            rtsCts;
    logic            stop2;
    usbu_parity_type parity;
    logic            len8;
  } usbu_ctrl_type;
  typedef struct packed {
    logic [3:0]             invert;
    logic [3:0]             highDrive;
    usbu_cfg_func_type [3:0] cfgFunc;
    logic [3:0]             cfgDrive;
  } usbu_nv_type;
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oeN;
    logic [3:0] highDrive;
  } usbu_pins_type;
endpackage

// ### design/usbu_core.sv
/*
  USB bridge UART core: two byte FIFOs, fractional baud generator, UART with flow control,
  bit-bang port with strobes, four configuration pins and a plain register port.
  Assumes one 25 MHz clock, synchronous reset, and pins that are asynchronous to it.
*/
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "usbu_regs.svh"

module usbu_fifo
  import usbu_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       pushValid,
  output logic            pushReady,
  input  wire logic [7:0] pushData,
  output logic            popValid,
  input  wire logic       popReady,
  output logic [7:0]      popData,
  output logic [9:0]      level
);
  logic [7:0]               mem [0:`USBU_FIFO_DEPTH-1];
  logic [`USBU_FIFO_AW-1:0] wrPtr;
  logic [`USBU_FIFO_AW-1:0] rdPtr;
  logic [9:0]               count;
  wire doPush = pushValid && pushReady;
  wire doPop  = popValid && popReady;
  assign pushReady = (count != 10'(`USBU_FIFO_DEPTH));
  assign popValid  = (count != 10'h000);
  assign popData   = mem[rdPtr];
  assign level     = count;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= 10'h000;
    end else begin
      if (doPush) wrPtr <= wrPtr + 9'h001;
      if (doPop) rdPtr <= rdPtr + 9'h001;
      count <= count + {9'h000, doPush} - {9'h000, doPop};
    end
  end
  // Storage has no reset; the pointers guard it
  always_ff @(posedge core_clk) begin
    if (doPush) mem[wrPtr] <= pushData;
  end
endmodule // usbu_fifo

module usbu_core
  import usbu_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   reset_n,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic   regWr,
  input  wire logic   regRd,
  output logic [31:0] regRdData,
  input  usbu_nv_type nvConfig,
  input  wire logic [3:0]  pinIn,
  output usbu_pins_type    pins,
  output logic [3:0]  cfgPinOut,
  output logic [3:0]  cfgPinHighDrive
);
  // ****************************************
  // Functions
  // ****************************************
  function automatic logic par_bit(input usbu_parity_type p, input logic [7:0] d,
                                   input logic len8);
    logic x;
    x = ^(len8 ? d : {1'b0, d[6:0]});
    case (p)
      USBU_PAR_ODD:  par_bit = ~x;
      USBU_PAR_EVEN: par_bit = x;
      USBU_PAR_MARK: par_bit = 1'b1;
      default:       par_bit = 1'b0;
    endcase
  endfunction

  function automatic logic cfg_level(input usbu_cfg_func_type f, input logic txEn,
                                     input logic wrN, input logic rdN, input logic ck);
    case (f)
      CFG_DRV1:  cfg_level = 1'b1;
      CFG_RS485: cfg_level = txEn;
      CFG_WRSTB: cfg_level = wrN;
      CFG_RDSTB: cfg_level = rdN;
      CFG_CLK:   cfg_level = ck;
      default:   cfg_level = 1'b0;
    endcase
  endfunction

  // ****************************************
  // Registers and pin synchroniser
  // ****************************************
  usbu_ctrl_type ctrl;
  logic [16:0]   baudReg;
  logic [3:0]    dirReg;
  logic [3:0]    pinMeta;
  logic [3:0]    pinSync;
  logic frameErr, breakSeen, overrun, parErr, hostDrop, xoffHold;
  logic [7:0]  outData;
  logic [7:0]  inData;
  logic [9:0]  inLevel;
  logic        outValid, outReady, inValid, inReady;
  wire [3:0]   pinLvl = pinSync ^ nvConfig.invert;
  wire isUart = ctrl.mode == USBU_MODE_UART;
  wire isAbb  = ctrl.mode == USBU_MODE_ABB;
  wire isSbb  = ctrl.mode == USBU_MODE_SBB;
  wire isBb   = isAbb || isSbb;
  wire wrCtrl = regWr && regAddr == `USBU_CTRL_ADDR;
  wire wrBaud = regWr && regAddr == `USBU_BAUD_ADDR;
  wire wrStat = regWr && regAddr == `USBU_STAT_ADDR;
  wire wrDat  = regWr && regAddr == `USBU_DATA_ADDR;
  wire wrDir  = regWr && regAddr == `USBU_DIR_ADDR;
  wire rdDat  = regRd && regAddr == `USBU_DATA_ADDR;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pinMeta <= 4'hF;
      pinSync <= 4'hF;
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

  // ****************************************
  // Baud generator
  // ****************************************
  // Zero integer means 16384; integer one drops the fraction
  wire [13:0] baudN = baudReg[`USBU_BAUD_N +: 14];
  wire [2:0]  baudFrac = baudReg[`USBU_BAUD_FRAC +: 3];
  wire [17:0] n8 = (baudN == 14'h0000) ? 18'h20000 : {1'b0, baudN, 3'h0};
  wire [17:0] div8 = (baudN == 14'h0001) ? n8 : n8 + {15'h0000, baudFrac};
  // Tick rate = 48 MHz * 8 / div8, scaled to the core clock; caps at one tick a cycle
  wire [22:0] accThr = 23'(`USBU_CLK_MHZ) * {5'h00, div8};
  wire [23:0] accInc = 24'(`USBU_REF_MHZ * 8);
  logic [22:0] acc;
  wire [23:0] accSum = {1'b0, acc} + accInc;
  wire baudTick = accSum >= {1'b0, accThr};
  always_ff @(posedge core_clk) begin
    if (!reset_n) acc <= 23'h000000;
    else acc <= baudTick ? 23'(accSum - {1'b0, accThr}) : accSum[22:0];
  end

  // ****************************************
  // UART transmitter
  // ****************************************
  usbu_ser_state_type txState;
  logic [4:0] txCnt;
  logic [2:0] txBit;
  logic [7:0] txShift;
  logic       txPar;
  wire [2:0] lastBit = ctrl.len8 ? 3'h7 : 3'h6;
  wire hasPar = ctrl.parity != USBU_PAR_NONE;
  wire ctsOk = !ctrl.rtsCts || !pinLvl[3];
  wire txGo = baudTick && txState == SER_IDLE && outValid && ctsOk && !xoffHold
              && isUart && !ctrl.brk;
  wire txBitEnd = baudTick && txCnt[3:0] == 4'hF;
  wire txStopEnd = baudTick && txCnt == (ctrl.stop2 ? 5'h1F : 5'h0F);
  wire txEnable = txState != SER_IDLE;
  wire txLevel = ctrl.brk ? 1'b0 :
                 txState == SER_START ? 1'b0 :
                 txState == SER_DATA ? txShift[0] :
                 txState == SER_PAR ? txPar : 1'b1;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      txState <= SER_IDLE;
      txCnt   <= 5'h00;
      txBit   <= 3'h0;
      txShift <= 8'hFF;
      txPar   <= 1'b0;
    end else begin
      if (txState == SER_IDLE || (txBitEnd && txState != SER_STOP)) txCnt <= 5'h00;
      else if (baudTick) txCnt <= txCnt + 5'h01;
      case (txState)
        SER_IDLE: if (txGo) begin
          txState <= SER_START;
          txShift <= outData;
          txPar   <= par_bit(ctrl.parity, outData, ctrl.len8);
        end
        SER_START: if (txBitEnd) begin
          txState <= SER_DATA;
          txBit   <= 3'h0;
        end
        SER_DATA: if (txBitEnd) begin
          txShift <= {1'b1, txShift[7:1]};
          txBit   <= txBit + 3'h1;
          if (txBit == lastBit) txState <= hasPar ? SER_PAR : SER_STOP;
        end
        SER_PAR: if (txBitEnd) txState <= SER_STOP;
        SER_STOP: if (txStopEnd) txState <= SER_IDLE;
        default: txState <= SER_IDLE;
      endcase
    end
  end

  // ****************************************
  // UART receiver
  // ****************************************
  usbu_ser_state_type rxState;
  logic [3:0] rxCnt;
  logic [2:0] rxBit;
  logic [7:0] rxShift;
  logic       rxArmed;
  wire rxLine = pinLvl[1];
  wire rxBitEnd = baudTick && rxCnt == 4'hF;
  wire [7:0] rxByte = ctrl.len8 ? rxShift : {1'b0, rxShift[7:1]};
  wire rxDone = rxState == SER_STOP && rxBitEnd;
  wire setFe = rxDone && !rxLine;
  wire setBrk = setFe && rxByte == 8'h00;
  wire isFlow = ctrl.xon && (rxByte == `USBU_XON || rxByte == `USBU_XOFF);
  wire rxDeliver = rxDone && rxLine && isUart && !isFlow;
  wire setPe = rxState == SER_PAR && rxBitEnd
               && rxLine != par_bit(ctrl.parity, rxByte, ctrl.len8);
  // Arming stops a held break from restarting frames back to back
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rxState <= SER_IDLE;
      rxCnt   <= 4'h0;
      rxBit   <= 3'h0;
      rxShift <= 8'h00;
      rxArmed <= 1'b0;
    end else begin
      if (rxState == SER_IDLE || (rxState == SER_START && rxCnt == 4'h7 && baudTick))
        rxCnt <= 4'h0;
      else if (baudTick) rxCnt <= rxCnt + 4'h1;
      case (rxState)
        SER_IDLE: if (baudTick) begin
          if (rxLine) rxArmed <= 1'b1;
          else if (rxArmed && isUart) begin
            rxState <= SER_START;
            rxArmed <= 1'b0;
          end
        end
        SER_START: if (baudTick && rxCnt == 4'h7) begin
          rxState <= rxLine ? SER_IDLE : SER_DATA;
          rxBit   <= 3'h0;
        end
        SER_DATA: if (rxBitEnd) begin
          rxShift <= {rxLine, rxShift[7:1]};
          rxBit   <= rxBit + 3'h1;
          if (rxBit == lastBit) rxState <= hasPar ? SER_PAR : SER_STOP;
        end
        SER_PAR: if (rxBitEnd) rxState <= SER_STOP;
        SER_STOP: if (rxBitEnd) rxState <= SER_IDLE;
        default: rxState <= SER_IDLE;
      endcase
    end
  end

  // ****************************************
  // Bit-bang port
  // ****************************************
  logic [3:0] bbTickCnt;
  logic [3:0] bbOut;
  logic       wrStbN, rdStbN, clkDiv;
  wire bbTick = baudTick && bbTickCnt == 4'hF;
  wire bbWrite = bbTick && isBb && outValid;
  // Sync mode samples what the pins showed before this write lands
  wire bbRead = bbTick && (isAbb || (isSbb && outValid));
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bbTickCnt <= 4'h0;
      bbOut     <= 4'hF;
      wrStbN    <= 1'b1;
      rdStbN    <= 1'b1;
      clkDiv    <= 1'b0;
    end else begin
      if (baudTick) bbTickCnt <= bbTickCnt + 4'h1;
      if (bbWrite) bbOut <= outData[3:0];
      wrStbN <= !bbWrite;
      rdStbN <= !bbRead;
      clkDiv <= !clkDiv;
    end
  end

  // ****************************************
  // FIFOs
  // ****************************************
  wire outPop = txGo || bbWrite;
  wire inPush = rxDeliver || bbRead;
  wire [7:0] inPushData = bbRead ? {4'h0, pinLvl} : rxByte;
  usbu_fifo u_out_fifo (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .pushValid (wrDat),
    .pushReady (outReady),
    .pushData  (regWrData[7:0]),
    .popValid  (outValid),
    .popReady  (outPop),
    .popData   (outData),
    .level     ()
  );
  usbu_fifo u_in_fifo (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .pushValid (inPush),
    .pushReady (inReady),
    .pushData  (inPushData),
    .popValid  (inValid),
    .popReady  (rdDat),
    .popData   (inData),
    .level     (inLevel)
  );

  // ****************************************
  // Register file
  // ****************************************
  // Sticky flags: set wins over a write-one clear
  wire setOvr = inPush && !inReady;
  wire setDrop = wrDat && !outReady;
  wire [7:0] statVec = {hostDrop, xoffHold, !inValid, !outValid,
                        parErr, overrun, breakSeen, frameErr};
  // Empty reads give zero; storage has no reset and would show unknowns
  wire [7:0] inByte = inValid ? inData : 8'h00;
  wire [31:0] rdMux = (regAddr == `USBU_CTRL_ADDR) ? {22'h000000, ctrl} :
                      (regAddr == `USBU_BAUD_ADDR) ? {15'h0000, baudReg} :
                      (regAddr == `USBU_STAT_ADDR) ? {24'h000000, statVec} :
                      (regAddr == `USBU_DATA_ADDR) ? {23'h000000, inValid, inByte} :
                      (regAddr == `USBU_DIR_ADDR) ? {28'h0000000, dirReg} : 32'h00000000;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl      <= usbu_ctrl_type'(`USBU_CTRL_RST);
      baudReg   <= `USBU_BAUD_RST;
      dirReg    <= `USBU_DIR_RST;
      regRdData <= 32'h00000000;
      frameErr  <= 1'b0;
      breakSeen <= 1'b0;
      overrun   <= 1'b0;
      parErr    <= 1'b0;
      hostDrop  <= 1'b0;
      xoffHold  <= 1'b0;
    end else begin
      if (wrCtrl) ctrl <= usbu_ctrl_type'(regWrData[9:0]);
      if (wrBaud) baudReg <= regWrData[16:0];
      if (wrDir) dirReg <= regWrData[3:0];
      regRdData <= regRd ? rdMux : 32'h00000000;
      frameErr  <= setFe || (frameErr && !(wrStat && regWrData[`USBU_ST_FERR]));
      breakSeen <= setBrk || (breakSeen && !(wrStat && regWrData[`USBU_ST_BRK]));
      overrun   <= setOvr || (overrun && !(wrStat && regWrData[`USBU_ST_OVR]));
      parErr    <= setPe || (parErr && !(wrStat && regWrData[`USBU_ST_PERR]));
      hostDrop  <= setDrop || (hostDrop && !(wrStat && regWrData[`USBU_ST_DROP]));
      if (!ctrl.xon) xoffHold <= 1'b0;
      else if (rxDone && rxLine && rxByte == `USBU_XOFF) xoffHold <= 1'b1;
      else if (rxDone && rxLine && rxByte == `USBU_XON) xoffHold <= 1'b0;
    end
  end

  // ****************************************
  // Pin outputs
  // ****************************************
  // Pin 0 transmit, 1 receive, 2 RTS, 3 CTS; RTS low means room
  wire rtsLvl = ctrl.rtsCts && (inLevel >= `USBU_RTS_LIMIT);
  wire [3:0] next_pinOut = isBb ? bbOut : {1'b1, rtsLvl, 1'b1, txLevel};
  wire [3:0] next_pinOeN = isBb ? ~dirReg : 4'hA;
  wire [3:0] next_cfgOut;
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_cfg
    assign next_cfgOut[gi] = cfg_level(nvConfig.cfgFunc[gi], txEnable,
                                       wrStbN, rdStbN, clkDiv);
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pins            <= '{out: 4'hF, oeN: 4'hF, highDrive: 4'h0};
      cfgPinOut       <= 4'h0;
      cfgPinHighDrive <= 4'h0;
    end else begin
      pins.out        <= next_pinOut ^ nvConfig.invert;
      pins.oeN        <= next_pinOeN;
      pins.highDrive  <= nvConfig.highDrive;
      cfgPinOut       <= next_cfgOut;
      cfgPinHighDrive <= nvConfig.cfgDrive;
    end
  end
endmodule // usbu_core

// ### sim/usbu_core_chk.sv
/*
  Checker of the bridge UART core, watching only the top module's ports.
  Assumes one clock, synchronous active-low reset, bound from the bench top.
*/
`timescale 1ns/1ps
module usbu_core_chk
  import usbu_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic [3:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdData,
  input usbu_nv_type      nvConfig,
  input wire logic [3:0]  pinIn,
  input usbu_pins_type    pins,
  input wire logic [3:0]  cfgPinOut,
  input wire logic [3:0]  cfgPinHighDrive
);
  // ****************************************
  // Port relations
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Reset itself is the cause here, so nothing disables it
  property p_resetState;
    disable iff (1'b0)
    !reset_n |=> pins.out == 4'hF && pins.oeN == 4'hF && pins.highDrive == 4'h0
      && cfgPinOut == 4'h0 && regRdData == 32'h0;
  endproperty
  a_resetState: assert property (p_resetState) else $error("reset state wrong");
  property p_readIdle;
    !regRd |=> regRdData == 32'h0;
  endproperty
  a_readIdle: assert property (p_readIdle) else $error("read data without read");
  property p_highDrive;
    reset_n |=> pins.highDrive == $past(nvConfig.highDrive);
  endproperty
  a_highDrive: assert property (p_highDrive) else $error("line drive wrong");
  property p_cfgDrive;
    $past(reset_n) |-> cfgPinHighDrive == $past(nvConfig.cfgDrive);
  endproperty
  a_cfgDrive: assert property (p_cfgDrive) else $error("config pin drive wrong");
  property p_drive1;
    reset_n && nvConfig.cfgFunc[1] == CFG_DRV1 |=> cfgPinOut[1];
  endproperty
  a_drive1: assert property (p_drive1) else $error("constant high pin low");
  property p_wrStrobe;
    nvConfig.cfgFunc[2] == CFG_WRSTB && $fell(cfgPinOut[2]) |=> cfgPinOut[2] [*8];
  endproperty
  a_wrStrobe: assert property (p_wrStrobe) else $error("write strobe shape");
  property p_rdStrobe;
    nvConfig.cfgFunc[3] == CFG_RDSTB && $fell(cfgPinOut[3])
      |=> $rose(cfgPinOut[3]) ##1 cfgPinOut[3] [*6];
  endproperty
  a_rdStrobe: assert property (p_rdStrobe) else $error("read strobe shape");
  property p_clkOut;
    reset_n && $past(reset_n) && nvConfig.cfgFunc[1] == CFG_CLK
      |=> cfgPinOut[1] != $past(cfgPinOut[1]);
  endproperty
  a_clkOut: assert property (p_clkOut) else $error("clock pin not toggling");
endmodule // usbu_core_chk

// ### sim/usbu_peer.sv
/*
  Serial peer: receives frames from the core's transmit line, sends frames, drives CTS.
  Assumes bit times in ns given by the caller; lines idle at mark.
*/
`timescale 1ns/1ps
module usbu_peer (
  input  wire logic txLine,
  output logic      rxLine,
  output logic      ctsLine
);
  // ****************************************
  // Line behaviour
  // ****************************************
  initial begin
    rxLine  = 1'b1;
    ctsLine = 1'b0;
  end
  task automatic setCts(input logic v);
    ctsLine <= v;
  endtask
  // Returns at mid of the last bit, while the sender still transmits
  task automatic recv(input int n, input real ns, output logic [11:0] bits, output logic ok);
    int waited;
    waited = 0;
    bits = 12'h000;
    while (txLine !== 1'b0 && waited < 4000) begin
      #10;
      waited++;
    end
    ok = (waited < 4000);
    #(ns / 2.0);
    for (int i = 0; i < n; i++) begin
      bits[i] = txLine;
      if (i < n - 1) #(ns);
    end
  endtask
  task automatic send(input logic [11:0] bits, input int n, input real ns);
    for (int i = 0; i < n; i++) begin
      rxLine <= bits[i];
      #(ns);
    end
    rxLine <= 1'b1;
  endtask
endmodule // usbu_peer

// ### sim/test_usb_uart_bitbang_core.sv
/*
  Self-checking bench of the bridge UART core.
  Assumes the serial peer on the lines and pull-ups on undriven port pins.
*/
`timescale 1ns/1ps
`include "usbu_regs.svh"
module test_usb_uart_bitbang_core;
  import usbu_pkg::*;
  // ****************************************
  // Wiring
  // ****************************************
  logic          core_clk;
  logic          reset_n;
  logic [3:0]    regAddr;
  logic [31:0]   regWrData;
  logic          regWr;
  logic          regRd;
  logic [31:0]   regRdData;
  usbu_nv_type   nvConfig;
  usbu_pins_type pins;
  logic [3:0]    cfgPinOut;
  logic [3:0]    cfgPinHighDrive;
  logic          rxLine;
  logic          ctsLine;
  wire  [3:0]    pinLine;
  int            badCount;
  int            testsRun;
  int            nw;
  int            nr;
  logic [31:0]   d;
  logic [11:0]   bits;
  logic          ok;
  logic [3:0]    rowAddr [7];
  logic [31:0]   rowExp [7];
  real           b2;
  real           b35;
  // Unknown enables before reset count as released
  assign pinLine[0] = pins.oeN[0] !== 1'b0 ? 1'b1 : pins.out[0];
  assign pinLine[1] = pins.oeN[1] !== 1'b0 ? rxLine : pins.out[1];
  assign pinLine[2] = pins.oeN[2] !== 1'b0 ? 1'b1 : pins.out[2];
  assign pinLine[3] = pins.oeN[3] !== 1'b0 ? ctsLine : pins.out[3];
  usbu_core usbu_core_i (
    .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .nvConfig(nvConfig),
    .pinIn(pinLine), .pins(pins), .cfgPinOut(cfgPinOut), .cfgPinHighDrive(cfgPinHighDrive)
  );
  usbu_peer usbu_peer_i (.txLine(pinLine[0]), .rxLine(rxLine), .ctsLine(ctsLine));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      badCount++;
    end
  endtask
  task automatic regWrite(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= v;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic regRead(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    v = regRdData;
  endtask
  function automatic logic [11:0] f8(input logic [7:0] v);
    return {3'b001, v, 1'b0};
  endfunction
  task automatic txExpect(input int n, input real ns, input logic [11:0] exp);
    usbu_peer_i.recv(n, ns, bits, ok);
    if (ok !== 1'b1) begin
      badCount++;
      printVerdict();
    end
    check({20'h0, bits}, {20'h0, exp});
  endtask
  // Counts low cycles over 60 clocks: 0-3 port lines, 4-7 config pins
  task automatic lowCycles(input int sel, output int c);
    c = 0;
    repeat (60) begin
      @(negedge core_clk);
      if ((sel < 4 ? pinLine[sel] : cfgPinOut[sel - 4]) !== 1'b1) c++;
    end
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    reset_n = 1'b0;
    regAddr = 4'h0;
    regWrData = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    badCount = 0;
    testsRun = 0;
    b2 = 2000.0 / 3.0;
    b35 = 3500.0 / 3.0;
    nvConfig.invert = 4'h0;
    nvConfig.highDrive = 4'h5;
    nvConfig.cfgDrive = 4'h9;
    nvConfig.cfgFunc[0] = CFG_RS485;
    nvConfig.cfgFunc[1] = CFG_DRV1;
    nvConfig.cfgFunc[2] = CFG_WRSTB;
    nvConfig.cfgFunc[3] = CFG_RDSTB;
    rowAddr = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hF};
    rowExp = '{32'h1, 32'h10138, 32'h30, 32'h0, 32'h0, 32'h0, 32'h0};
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    check({24'h0, pins.out, pins.oeN}, 32'hBA);
    for (int i = 0; i < 7; i++) begin
      regRead(rowAddr[i], d);
      check(d, rowExp[i]);
    end
    regWrite(`USBU_BAUD_ADDR, 32'h2);
    regRead(`USBU_BAUD_ADDR, d);
    check(d, 32'h2);
    regWrite(`USBU_DATA_ADDR, 32'hA5);
    txExpect(10, b2, f8(8'hA5));
    check({31'h0, cfgPinOut[0]}, 32'h1);
    repeat (30) @(posedge core_clk);
    check({31'h0, cfgPinOut[0]}, 32'h0);
    regWrite(`USBU_CTRL_ADDR, 32'h14);
    regWrite(`USBU_DATA_ADDR, 32'h5A);
    txExpect(11, b2, {3'b011, 1'b0, 7'h5A, 1'b0});
    regWrite(`USBU_CTRL_ADDR, 32'h1);
    regWrite(`USBU_BAUD_ADDR, 32'h10003);
    regWrite(`USBU_DATA_ADDR, 32'h3C);
    txExpect(10, b35, f8(8'h3C));
    regWrite(`USBU_BAUD_ADDR, 32'h2);
    usbu_peer_i.send(f8(8'h96), 10, b2);
    repeat (30) @(posedge core_clk);
    regRead(`USBU_DATA_ADDR, d);
    check(d, 32'h196);
    regRead(`USBU_DATA_ADDR, d);
    check(d & 32'h100, 32'h0);
    usbu_peer_i.send(12'h000, 10, b2);
    repeat (30) @(posedge core_clk);
    regRead(`USBU_STAT_ADDR, d);
    check(d & 32'h3, 32'h3);
    regWrite(`USBU_STAT_ADDR, 32'h8F);
    regRead(`USBU_STAT_ADDR, d);
    check(d & 32'h8F, 32'h0);
    regWrite(`USBU_CTRL_ADDR, 32'h81);
    repeat (50) @(posedge core_clk);
    check({31'h0, pinLine[0]}, 32'h0);
    regWrite(`USBU_CTRL_ADDR, 32'h41);
    usbu_peer_i.send(f8(8'h13), 10, b2);
    repeat (30) @(posedge core_clk);
    regRead(`USBU_STAT_ADDR, d);
    check(d & 32'h40, 32'h40);
    regWrite(`USBU_DATA_ADDR, 32'h77);
    lowCycles(0, nw);
    check(nw, 0);
    fork
      usbu_peer_i.send(f8(8'h11), 10, b2);
      txExpect(10, b2, f8(8'h77));
    join
    regWrite(`USBU_CTRL_ADDR, 32'h21);
    usbu_peer_i.setCts(1'b1);
    regWrite(`USBU_DATA_ADDR, 32'h42);
    lowCycles(0, nw);
    check(nw, 0);
    check({31'h0, pinLine[2]}, 32'h0);
    usbu_peer_i.setCts(1'b0);
    txExpect(10, b2, f8(8'h42));
    regWrite(`USBU_DIR_ADDR, 32'hF);
    regWrite(`USBU_CTRL_ADDR, 32'h101);
    regWrite(`USBU_DATA_ADDR, 32'h9);
    fork
      lowCycles(6, nw);
      lowCycles(7, nr);
    join
    check(nw, 1);
    check({31'h0, nr >= 3 && nr <= 4}, 32'h1);
    check({24'h0, pins.out, pins.oeN}, 32'h90);
    regRead(`USBU_DATA_ADDR, d);
    check(d & 32'h1F0, 32'h100);
    regWrite(`USBU_DIR_ADDR, 32'h1);
    regWrite(`USBU_CTRL_ADDR, 32'h201);
    d = 32'h100;
    for (int i = 0; i < 600 && d[8] === 1'b1; i++) regRead(`USBU_DATA_ADDR, d);
    check(d & 32'h100, 32'h0);
    regWrite(`USBU_DATA_ADDR, 32'h1);
    regWrite(`USBU_DATA_ADDR, 32'h0);
    repeat (80) @(posedge core_clk);
    check({31'h0, pinLine[0]}, 32'h0);
    regRead(`USBU_DATA_ADDR, d);
    regRead(`USBU_DATA_ADDR, d);
    check(d, 32'h107);
    regRead(`USBU_DATA_ADDR, d);
    check(d & 32'h100, 32'h0);
    reset_n <= 1'b0;
    nvConfig.invert <= 4'hF;
    nvConfig.cfgFunc[1] <= CFG_CLK;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    check({24'h0, pins.out, pins.oeN}, 32'h4A);
    repeat (10) @(posedge core_clk);
    printVerdict();
  end
endmodule // test_usb_uart_bitbang_core
bind usbu_core usbu_core_chk usbu_core_chk_i (
  .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .nvConfig(nvConfig),
  .pinIn(pinIn), .pins(pins), .cfgPinOut(cfgPinOut), .cfgPinHighDrive(cfgPinHighDrive)
);
